// *** src/mcfc_top.sv ***
// Flow-control register bank of one motor calculation channel.
// Assumes a single-cycle register port master synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none
module mcfc_top
  import mcfc_pkg::*;
#(
  parameter bit CHANNEL = 1'b0
)
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  input wire logic [VALUE_W-1:0] sine_value_in,
  input wire logic [VALUE_W-1:0] cosine_value_in,
  input wire logic [SECTOR_W-1:0] sector_value_in,
  input wire logic capture_in,
  input wire logic [TRIG_W-1:0] first_trigger_mode_in,
  input wire logic [TRIG_W-1:0] second_trigger_mode_in,
  output logic adc_unit_a_out,
  output logic adc_unit_b_out,
  output logic driver_channel_out,
  output logic [1:0] sense_mode_out,
  output logic single_shunt_out,
  output logic pwm_shift_out,
  output logic two_phase_out,
  output logic [15:0] conversion_time_out,
  output logic conversion_time_active_out,
  output logic [VALUE_W-1:0] held_sine_out,
  output logic [VALUE_W-1:0] held_cosine_out,
  output logic [SECTOR_W-1:0] held_sector_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register fields

  logic hold_disable;
  logic [1:0] converter_unit_select;
  logic driver_channel_select;
  mcfc_sense_t sense_mode;
  logic pwm_shift_enable;
  logic two_phase_modulation;
  logic [15:0] conversion_time;
  logic trigger_ok;
  logic pairing_ok;
  logic next_trigger_ok;
  logic next_pairing_ok;
  logic next_conv_active;
  logic [DATA_W-1:0] flow_word;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] next_rdata;

  // Reserved bits are not stored, so they always read back as zero
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      hold_disable <= 1'b0;
      converter_unit_select <= CU_RST;
      driver_channel_select <= 1'b0;
      sense_mode <= SENSE_THREE_SHUNT;
      pwm_shift_enable <= 1'b0;
      two_phase_modulation <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == OFS_FLOW)
    begin
      hold_disable <= reg_wdata_in[HOLD_DIS_BIT];
      converter_unit_select <= reg_wdata_in[CU_LSB+1:CU_LSB];
      driver_channel_select <= reg_wdata_in[DRV_BIT];
      sense_mode <= mcfc_sense_t'(reg_wdata_in[SENSE_LSB+1:SENSE_LSB]);
      pwm_shift_enable <= reg_wdata_in[SHIFT_BIT];
      two_phase_modulation <= reg_wdata_in[TWOPH_BIT];
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      conversion_time <= CONV_RST;
    else if (reg_wr_in && reg_addr_in == OFS_CONV)
      conversion_time <= reg_wdata_in[15:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration checks shown in the status register

  always_comb
  begin
    unique case (sense_mode)
      SENSE_SHUNT_UP:
        next_trigger_ok = (second_trigger_mode_in == TRIG_UP) &&
          (first_trigger_mode_in == TRIG_UP ||
           first_trigger_mode_in == TRIG_BOTTOM);
      SENSE_SHUNT_DOWN:
        next_trigger_ok = (first_trigger_mode_in == TRIG_DOWN) &&
          (second_trigger_mode_in == TRIG_DOWN ||
           second_trigger_mode_in == TRIG_BOTTOM);
      SENSE_THREE_SHUNT,
      SENSE_TWO_SENSOR:
        next_trigger_ok = 1'b1;
    endcase
  end

  // Software owns the pairing; the block only reports a bad setup
  always_comb
  begin
    if (CHANNEL == 1'b0)
      next_pairing_ok = (converter_unit_select != CU_B_ONLY) &&
        (driver_channel_select == 1'b0);
    else
      next_pairing_ok = (converter_unit_select != CU_A_ONLY) &&
        (driver_channel_select == 1'b1);
  end

  assign next_conv_active = pwm_shift_enable &&
    (sense_mode == SENSE_SHUNT_UP || sense_mode == SENSE_SHUNT_DOWN);

  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      trigger_ok <= 1'b1;
      pairing_ok <= 1'b0;
    end
    else
    begin
      trigger_ok <= next_trigger_ok;
      pairing_ok <= next_pairing_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Controls toward the driver and converter units

  // One register stage keeps every output glitch-free at the cost of a cycle
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      adc_unit_a_out <= 1'b1;
      adc_unit_b_out <= 1'b0;
      driver_channel_out <= 1'b0;
      sense_mode_out <= 2'h0;
      single_shunt_out <= 1'b0;
      pwm_shift_out <= 1'b0;
      two_phase_out <= 1'b0;
      conversion_time_out <= CONV_RST;
      conversion_time_active_out <= 1'b0;
    end
    else
    begin
      adc_unit_a_out <= (converter_unit_select != CU_B_ONLY);
      adc_unit_b_out <= (converter_unit_select != CU_A_ONLY);
      driver_channel_out <= driver_channel_select;
      sense_mode_out <= sense_mode;
      single_shunt_out <= (sense_mode == SENSE_SHUNT_UP) ||
        (sense_mode == SENSE_SHUNT_DOWN);
      pwm_shift_out <= pwm_shift_enable;
      two_phase_out <= two_phase_modulation;
      conversion_time_out <= next_conv_active ? conversion_time : CONV_RST;
      conversion_time_active_out <= next_conv_active;
    end
  end

  mcfc_held_copy u_held_copy (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .hold_disable_in(hold_disable),
    .capture_in(capture_in),
    .sine_value_in(sine_value_in),
    .cosine_value_in(cosine_value_in),
    .sector_value_in(sector_value_in),
    .held_sine_out(held_sine_out),
    .held_cosine_out(held_cosine_out),
    .held_sector_out(held_sector_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb
  begin
    flow_word = ZERO_WORD;
    flow_word[HOLD_DIS_BIT] = hold_disable;
    flow_word[CU_LSB+1:CU_LSB] = converter_unit_select;
    flow_word[DRV_BIT] = driver_channel_select;
    flow_word[SENSE_LSB+1:SENSE_LSB] = sense_mode;
    flow_word[SHIFT_BIT] = pwm_shift_enable;
    flow_word[TWOPH_BIT] = two_phase_modulation;
  end

  always_comb
  begin
    status_word = ZERO_WORD;
    status_word[STAT_TRIG_OK_BIT] = trigger_ok;
    status_word[STAT_PAIR_OK_BIT] = pairing_ok;
    status_word[STAT_CONV_ACT_BIT] = conversion_time_active_out;
  end

  always_comb
  begin
    next_rdata = ZERO_WORD;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        OFS_FLOW: next_rdata = flow_word;
        OFS_CONV: next_rdata = {16'h0000, conversion_time};
        OFS_STATUS: next_rdata = status_word;
        OFS_HELD_SIN: next_rdata = {16'h0000, held_sine_out};
        OFS_HELD_COS: next_rdata = {16'h0000, held_cosine_out};
        OFS_HELD_SEC: next_rdata = {28'h0000000, held_sector_out};
        default: next_rdata = ZERO_WORD;
      endcase
    end
  end

  // Data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      reg_rdata_out <= ZERO_WORD;
    else
      reg_rdata_out <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_flow_write;
    reg_wr_in && reg_addr_in == OFS_FLOW;
  endsequence

  sequence s_flow_read;
    reg_rd_in && reg_addr_in == OFS_FLOW;
  endsequence

  a_unit_select: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_write |=> ##1
      (adc_unit_a_out == ($past(reg_wdata_in[7:6], 2) != CU_B_ONLY)) &&
      (adc_unit_b_out == ($past(reg_wdata_in[7:6], 2) != CU_A_ONLY)))
    else $error("converter unit outputs disagree with written select");

  a_driver_select: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_write |=> ##1 driver_channel_out == $past(reg_wdata_in[4], 2))
    else $error("driver channel output disagrees with written select");

  a_sense_mode: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_write |=> ##1 (sense_mode_out == $past(reg_wdata_in[3:2], 2)) &&
      (single_shunt_out == $past(reg_wdata_in[3], 2)))
    else $error("sense mode output disagrees with written field");

  a_pwm_shift: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_write |=> ##1 pwm_shift_out == $past(reg_wdata_in[1], 2))
    else $error("PWM shift output disagrees with written bit");

  a_two_phase: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_write |=> ##1 two_phase_out == $past(reg_wdata_in[0], 2))
    else $error("modulation output disagrees with written bit");

  a_conv_gate: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (!single_shunt_out || !pwm_shift_out) |->
      (conversion_time_out == CONV_RST) && !conversion_time_active_out)
    else $error("conversion time passed outside single-shunt shift mode");

  a_held_path: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_write ##0 reg_wdata_in[9] ##1 !reg_wr_in |=>
      held_sine_out == $past(sine_value_in))
    else $error("held sine not following with holding disabled");

  a_read_reserved: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    s_flow_read |=> (reg_rdata_out[31:10] == 22'h000000) &&
      !reg_rdata_out[8] && !reg_rdata_out[5])
    else $error("reserved flow_control bits read nonzero");

  a_read_idle_zero: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !reg_rd_in |=> reg_rdata_out == ZERO_WORD)
    else $error("read data present without a read strobe");

  a_trigger_check: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (sense_mode == SENSE_SHUNT_DOWN && first_trigger_mode_in != TRIG_DOWN)
      |=> !trigger_ok)
    else $error("illegal down-count trigger setup not flagged");

endmodule
`default_nettype wire

// *** src/mcfc_pkg.sv ***
// Constants and types shared by the flow-control block and its held-copy unit.
// Assumes one 125 MHz clock and an 8-bit byte-address register port.
package mcfc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VALUE_W = 16;
  localparam int SECTOR_W = 4;
  localparam int TRIG_W = 3;

  // Register byte offsets
  localparam logic [7:0] OFS_FLOW = 8'h00;
  localparam logic [7:0] OFS_CONV = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_HELD_SIN = 8'h0C;
  localparam logic [7:0] OFS_HELD_COS = 8'h10;
  localparam logic [7:0] OFS_HELD_SEC = 8'h14;

  // Field positions of the flow_control register
  localparam int HOLD_DIS_BIT = 9;
  localparam int CU_LSB = 6;
  localparam int DRV_BIT = 4;
  localparam int SENSE_LSB = 2;
  localparam int SHIFT_BIT = 1;
  localparam int TWOPH_BIT = 0;

  // Field positions of the status register
  localparam int STAT_TRIG_OK_BIT = 0;
  localparam int STAT_PAIR_OK_BIT = 1;
  localparam int STAT_CONV_ACT_BIT = 2;

  // Reset values
  localparam logic [1:0] CU_RST = 2'h0;
  localparam logic [15:0] CONV_RST = 16'h0000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // Converter unit select codes
  localparam logic [1:0] CU_A_ONLY = 2'h0;
  localparam logic [1:0] CU_B_ONLY = 2'h1;

  // Driver trigger mode codes
  localparam logic [2:0] TRIG_UP = 3'h2;
  localparam logic [2:0] TRIG_DOWN = 3'h1;
  localparam logic [2:0] TRIG_BOTTOM = 3'h5;

  typedef enum logic [1:0] {
    SENSE_THREE_SHUNT,
    SENSE_TWO_SENSOR,
    SENSE_SHUNT_UP,
    SENSE_SHUNT_DOWN
  } mcfc_sense_t;

endpackage

// *** src/mcfc_held_copy.sv ***
// Held copies of sine, cosine and sector for one calculation channel.
// Assumes current values and the capture pulse are synchronous to mclk_in.
`timescale 1ns/1ps
`default_nettype none
module mcfc_held_copy
  import mcfc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hold_disable_in,
  input wire logic capture_in,
  input wire logic [VALUE_W-1:0] sine_value_in,
  input wire logic [VALUE_W-1:0] cosine_value_in,
  input wire logic [SECTOR_W-1:0] sector_value_in,
  output logic [VALUE_W-1:0] held_sine_out,
  output logic [VALUE_W-1:0] held_cosine_out,
  output logic [SECTOR_W-1:0] held_sector_out
);

  // Copies follow every cycle with holding disabled, else move only on a capture
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      held_sine_out <= '0;
      held_cosine_out <= '0;
      held_sector_out <= '0;
    end
    else if (hold_disable_in || capture_in)
    begin
      held_sine_out <= sine_value_in;
      held_cosine_out <= cosine_value_in;
      held_sector_out <= sector_value_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  a_held_follows: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    hold_disable_in |=> (held_sine_out == $past(sine_value_in)) &&
      (held_cosine_out == $past(cosine_value_in)) &&
      (held_sector_out == $past(sector_value_in)))
    else $error("held copy does not follow current value");

  a_held_keeps: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (!hold_disable_in && !capture_in) |=> $stable(held_sine_out) &&
      $stable(held_cosine_out) && $stable(held_sector_out))
    else $error("held copy changed while holding");

endmodule
`default_nettype wire

// *** verification/mcfc_drv_model.sv ***
// Far-side model: driver trigger modes and current sin/cos/sector results.
// Assumes one clock; driver 0 modes come from the bench, driver 1 is fixed at TRIG_UP.
`timescale 1ns/1ps
`default_nettype none
module mcfc_drv_model
  import mcfc_pkg::*;
(
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic driver_channel_in,
  input wire logic [TRIG_W-1:0] first_mode_in,
  input wire logic [TRIG_W-1:0] second_mode_in,
  output logic [VALUE_W-1:0] sine_value_out,
  output logic [VALUE_W-1:0] cosine_value_out,
  output logic [SECTOR_W-1:0] sector_value_out,
  output logic [TRIG_W-1:0] first_trigger_mode_out,
  output logic [TRIG_W-1:0] second_trigger_mode_out
);
  logic [VALUE_W-1:0] count;
  ////////////////////////////////////////////////////////////////////////////
  // Results move every cycle so a stale held copy cannot pass
  always_ff @(posedge mclk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      count <= 16'h0000;
    else
      count <= count + 16'h1357;
  end
  assign sine_value_out = count;
  assign cosine_value_out = ~count;
  assign sector_value_out = count[3:0];
  ////////////////////////////////////////////////////////////////////////////
  // Driver 0 may be told to break the trigger pairing; driver 1 breaks it only in SENSE_SHUNT_DOWN
  assign first_trigger_mode_out =
    driver_channel_in ? TRIG_UP : first_mode_in;
  assign second_trigger_mode_out =
    driver_channel_in ? TRIG_UP : second_mode_in;
endmodule
`default_nettype wire

// *** verification/motor_calc_flow_control_tb_top.sv ***
// Self-checking bench for the flow-control register bank, channel 0.
// Assumes the one-cycle register port and the far-side model beside it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module motor_calc_flow_control_tb_top;
  import mcfc_pkg::*;
  logic mclk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, cap = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [2:0] tm0 = 3'h2, tm1 = 3'h2, ft, st;
  logic [15:0] ps, pc, hs, hc, ctime;
  logic [3:0] pse, hse;
  logic [1:0] mode;
  logic ua, ub, drv, single, shift, twoph, act;
  logic [35:0] v;
  logic [8:0] tbl [8];
  int fail_count = 0, checks = 0, cycles = 0;
  always #4 mclk = ~mclk;
  mcfc_top u_mcfc_top (.mclk_in(mclk), .nrst_in(nrst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .sine_value_in(ps), .cosine_value_in(pc),
    .sector_value_in(pse), .capture_in(cap), .first_trigger_mode_in(ft),
    .second_trigger_mode_in(st), .adc_unit_a_out(ua), .adc_unit_b_out(ub),
    .driver_channel_out(drv), .sense_mode_out(mode),
    .single_shunt_out(single), .pwm_shift_out(shift), .two_phase_out(twoph),
    .conversion_time_out(ctime), .conversion_time_active_out(act),
    .held_sine_out(hs), .held_cosine_out(hc), .held_sector_out(hse));
  mcfc_drv_model u_mcfc_drv_model (.mclk_in(mclk), .nrst_in(nrst),
    .driver_channel_in(drv), .first_mode_in(tm0), .second_mode_in(tm1),
    .sine_value_out(ps), .cosine_value_out(pc), .sector_value_out(pse),
    .first_trigger_mode_out(ft), .second_trigger_mode_out(st));
  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Sampling 1 ns after the edge keeps every check clear of update races
  task step;
    @(posedge mclk);
    #1;
  endtask
  // An idle cycle follows each strobe, so fields are visible on return
  task wr32(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    step;
    wr <= 1'b0;
    step;
  endtask
  task rd32(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    step;
    rd <= 1'b0;
    `CHK("read data", e, rdata)
    step;
  endtask
  task endt(input string nm);
    $display("test %s done", nm);
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Mode, first trigger, second trigger, expected trigger_ok
    tbl = '{9'h125, 9'h155, 9'h112, 9'h12A,
      9'h193, 9'h19B, 9'h1A4, 9'h1D2};
    repeat (2) @(posedge mclk);
    #1;
    nrst = 1'b1;
    step;
    `CHK("unit a", 1'b1, ua)
    `CHK("fields", 8'h00, {ub, drv, mode, single, shift, twoph, act})
    `CHK("held", 36'h0, {hs, hc, hse})
    rd32(OFS_FLOW, ZERO_WORD);
    rd32(OFS_CONV, ZERO_WORD);
    rd32(OFS_STATUS, 32'h00000003);
    rd32(8'hFC, ZERO_WORD);
    endt("reset");
    for (int i = 0; i < 4; i++)
    begin
      wr32(OFS_FLOW, 32'(i) << CU_LSB);
      `CHK("unit a", i != 1, ua)
      `CHK("unit b", i != 0, ub)
      step;
      rd32(OFS_STATUS, {30'h0, i != 1, 1'b1});
    end
    endt("converter");
    wr32(OFS_FLOW, 32'h00000013);
    `CHK("drv shift 2ph", 3'h7, {drv, shift, twoph})
    step;
    rd32(OFS_STATUS, 32'h00000001);
    wr32(OFS_FLOW, 32'h00000001);
    `CHK("drv shift 2ph", 3'h1, {drv, shift, twoph})
    endt("driver");
    wr32(OFS_CONV, 32'hFFFF1234);
    rd32(OFS_CONV, 32'h00001234);
    for (int i = 0; i < 8; i++)
    begin
      wr32(OFS_FLOW, {28'h0, 2'(i >> 1), i[0], 1'b0});
      `CHK("sense", 2'(i >> 1), mode)
      `CHK("single", i >= 4, single)
      `CHK("active", i >= 4 && i[0], act)
      `CHK("conv time", (i >= 4 && i[0]) ? 16'h1234 : 16'h0, ctime)
    end
    endt("sense");
    for (int i = 0; i < 8; i++)
    begin
      tm0 <= tbl[i][6:4];
      tm1 <= tbl[i][3:1];
      wr32(OFS_FLOW, {28'h0, tbl[i][8:7], 2'b10});
      step;
      rd32(OFS_STATUS, {29'h0, 2'b11, tbl[i][0]});
    end
    endt("triggers");
    wr32(OFS_FLOW, ZERO_WORD);
    cap <= 1'b1;
    v = {ps, pc, pse};
    step;
    cap <= 1'b0;
    `CHK("captured", v, {hs, hc, hse})
    repeat (3) step;
    `CHK("kept", v, {hs, hc, hse})
    rd32(OFS_HELD_SIN, {16'h0, v[35:20]});
    rd32(OFS_HELD_COS, {16'h0, v[19:4]});
    rd32(OFS_HELD_SEC, {28'h0, v[3:0]});
    wr32(OFS_FLOW, 32'h00000200);
    for (int i = 0; i < 3; i++)
    begin
      v = {ps, pc, pse};
      step;
      `CHK("follow", v, {hs, hc, hse})
    end
    endt("held");
    // Reserved bits 15-10, 8 and 5 are written as zero; 31-16 are read-only
    wr32(OFS_FLOW, 32'hFFFF02DF);
    rd32(OFS_FLOW, 32'h000002DF);
    nrst <= 1'b0;
    step;
    nrst <= 1'b1;
    step;
    rd32(OFS_FLOW, ZERO_WORD);
    endt("reserved");
    stop_test;
  end
endmodule
`default_nettype wire
